//--- pkg/itsds_pkg.sv
// constants, field layout and state type of the tone shaper and discovery sequencer
package itsds_pkg;
  // register byte addresses and region bases
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_LEVEL = 12'h008;
  localparam logic [3:0] REGION_CSR = 4'h0;
  localparam logic [3:0] REGION_MASK = 4'h1;
  localparam logic [3:0] REGION_OFFER = 4'h2;
  localparam logic [11:0] ADDR_TSS_BASE = 12'h800;
  // control register fields
  localparam int CTRL_LONG = 0;
  localparam int CTRL_FER = 1;
  localparam int CTRL_PROBE = 2;
  localparam int CTRL_UP = 3;
  localparam int CTRL_HS = 4;
  localparam int CTRL_SRST = 5;
  localparam int CTRL_ZFILL = 6;
  localparam int CTRL_PH_LO = 8;
  localparam int CTRL_PH_HI = 9;
  localparam logic [9:0] CTRL_RESET = 10'h000;
  // level register fields: nominal level low half, reference scale high half
  localparam int LVL_REF_LO = 16;
  localparam logic [31:0] LEVEL_RESET = 32'h0100_1000;
  // initialization phases as written by software
  localparam logic [1:0] PH_HS = 2'h0;
  localparam logic [1:0] PH_DISC = 2'h1;
  localparam logic [1:0] PH_TRAIN = 2'h2;
  localparam logic [1:0] PH_ANA = 2'h3;
  // tone gain is unsigned with eight fraction bits
  localparam logic [8:0] GAIN_ONE = 9'h100;
  localparam int GAIN_FRAC = 8;
  // symbol counts of the discovery states
  localparam logic [15:0] QUIET1_MIN = 16'h0200;
  localparam logic [15:0] QUIET1_MAX = 16'h106c;
  localparam logic [15:0] QUIET1_WAIT = 16'h0200;
  localparam logic [15:0] PILOT1_LEN = 16'h0080;
  localparam logic [15:0] QUIET2_LEN = 16'h0100;
  localparam logic [15:0] PILOT2_SHORT = 16'h0400;
  localparam logic [15:0] PILOT2_LONG = 16'h0f20;
  localparam logic [15:0] INVP_LEN = 16'h000a;
  // symbol period in ns and the clock period in ns
  localparam int SYM_PERIOD_NS = 250000;
  localparam int CLK_PERIOD_NS = 20;
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_QUIET1, ST_PILOT1, ST_QUIET2, ST_PILOT2, ST_INVP1, ST_QUIET3, ST_HANDOFF
  } itsds_state_e;
endpackage

//--- src/itsds_top.sv
// tone gain and blackout encoder with the first discovery states of the sequencer
`timescale 1ns/1ps
`default_nettype none
module itsds_top
  import itsds_pkg::*;
#(
  parameter int NSC = 256,
  parameter int NFFT = 512,
  parameter int DW = 16,
  parameter int SYM_DIV = SYM_PERIOD_NS / CLK_PERIOD_NS
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic hs_end_i,
  input wire logic remote_quiet_i,
  input wire logic pcb_done_i,
  input wire logic pcb_has_mask_i,
  input wire logic tone_valid_i,
  input wire logic [$clog2(2*NSC)-1:0] tone_idx_i,
  input wire logic signed [DW-1:0] map_re_i,
  input wire logic signed [DW-1:0] map_im_i,
  input wire logic [1:0] prbs_i,
  output logic z_valid_o,
  output logic [$clog2(2*NSC)-1:0] z_idx_o,
  output logic signed [DW-1:0] z_re_o,
  output logic signed [DW-1:0] z_im_o,
  output logic sym_tick_o
);
  localparam int NT = 2 * NSC;
  localparam int IW = $clog2(NT);
  localparam int NW = NT / 32;
  localparam int MINN = (NFFT < NT) ? NFFT : NT;
  localparam int DVW = $clog2(SYM_DIV + 1);

  // sparse pilot tone membership
  function automatic logic is_pilot(input logic [IW-1:0] idx);
    case (int'(idx))
      11, 23, 35, 47, 59, 64, 71, 83, 95, 107, 119, 143, 179, 203, 227, 251: is_pilot = 1'b1;
      default: is_pilot = 1'b0;
    endcase
  endfunction

  // signed value times unsigned fraction-8 scale, truncated to the data width
  function automatic logic signed [DW-1:0] scale(input logic signed [DW-1:0] x,
                                                 input logic [8:0] g);
    logic signed [DW+9:0] p;
    p = x * $signed({1'b0, g});
    scale = p[DW+GAIN_FRAC-1:GAIN_FRAC];
  endfunction

  // 4-QAM point: a set bit sends the negative level
  function automatic logic signed [DW-1:0] qam(input logic b, input logic signed [DW-1:0] lvl);
    qam = b ? -lvl : lvl;
  endfunction

  // register region decode
  function automatic logic in_region(input logic [11:0] a, input logic [3:0] reg_base);
    in_region = (a[11] == 1'b0) && (a[10:8] == reg_base[2:0]);
  endfunction

  logic [9:0] ctrl_q;
  logic [31:0] level_q;
  logic srst_q;
  logic [NT-1:0] mask_stage_q;
  logic [NT-1:0] mask_q;
  logic [NT-1:0] offer_q;
  logic [8:0] tss_q [NT];
  logic [DVW-1:0] div_q;
  logic tick_q;
  itsds_state_e state_q, state_d;
  logic [15:0] cnt_q;
  logic [15:0] wait_q;
  logic remote_q;
  logic ovr_q;
  logic [31:0] rd_d;
  logic [31:0] rdata_q;
  logic z_valid_q;
  logic [IW-1:0] z_idx_q;
  logic signed [DW-1:0] z_re_q, z_im_q, z_re_d, z_im_d;
  logic [IW-1:0] widx;

  assign widx = IW'(addr_i[10:2]);

  // control and level registers; soft reset is a one-cycle pulse
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RESET;
      level_q <= LEVEL_RESET;
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_SRST];
      if (wr_i && addr_i == ADDR_CTRL) begin
        ctrl_q <= wdata_i[9:0];
        ctrl_q[CTRL_SRST] <= 1'b0;
      end
      if (wr_i && addr_i == ADDR_LEVEL) begin
        level_q <= wdata_i;
      end
    end
  end

  // staging mask and offered set, written a word at a time
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_stage_q <= '0;
      offer_q <= '0;
    end else if (wr_i) begin
      for (int w = 0; w < NW; w++) begin
        if (in_region(addr_i, REGION_MASK) && int'(addr_i[7:2]) == w) begin
          mask_stage_q[w*32 +: 32] <= wdata_i;
        end
        if (in_region(addr_i, REGION_OFFER) && int'(addr_i[7:2]) == w) begin
          offer_q[w*32 +: 32] <= wdata_i;
        end
      end
    end
  end

  // tone gain table; resets to unity so an unloaded table is harmless
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NT; i++) begin
        tss_q[i] <= GAIN_ONE;
      end
    end else if (wr_i && addr_i[11] && int'(widx) < NT) begin
      tss_q[widx] <= wdata_i[8:0];
    end
  end

  // mask in force: taken over when the cutback message is done
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mask_q <= '0;
    end else if (pcb_done_i) begin
      if (pcb_has_mask_i) begin
        mask_q <= mask_stage_q;
      end else if (ctrl_q[CTRL_HS]) begin
        mask_q <= '0;
      end
      // without a handshake the previous mask simply stays in force
    end
  end

  // fixed divider from the one system clock; no rate switch exists
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= div_q == DVW'(SYM_DIV - 1);
      div_q <= (div_q == DVW'(SYM_DIV - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // next state; each timed discovery state exits on the tick that ends its last symbol
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (hs_end_i) begin
          state_d = ST_QUIET1;
        end
      end
      ST_QUIET1: begin
        // both the entry minimum and the wait after the later entry must pass
        if (tick_q && remote_q && cnt_q >= QUIET1_MIN - 1'b1 &&
            wait_q >= QUIET1_WAIT - 1'b1) begin
          state_d = ST_PILOT1;
        end
      end
      ST_PILOT1: begin
        if (tick_q && cnt_q == PILOT1_LEN - 1'b1) begin
          state_d = ST_QUIET2;
        end
      end
      ST_QUIET2: begin
        if (tick_q && cnt_q == QUIET2_LEN - 1'b1) begin
          state_d = ST_PILOT2;
        end
      end
      ST_PILOT2: begin
        // recovery from showtime forces the short length
        if (tick_q && cnt_q == ((ctrl_q[CTRL_LONG] && !ctrl_q[CTRL_FER]) ?
                                PILOT2_LONG : PILOT2_SHORT) - 1'b1) begin
          state_d = ctrl_q[CTRL_PROBE] ? ST_INVP1 : ST_QUIET3;
        end
      end
      ST_INVP1: begin
        if (tick_q && cnt_q == INVP_LEN - 1'b1) begin
          state_d = ST_HANDOFF;
        end
      end
      ST_QUIET3: state_d = ST_QUIET3;
      ST_HANDOFF: state_d = ST_HANDOFF;
      default: state_d = ST_IDLE;
    endcase
  end

  // state register with soft return to idle
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
    end else if (srst_q) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // symbols sent in the current state; cleared on every entry
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (srst_q || state_d != state_q) begin
      cnt_q <= '0;
    end else if (tick_q && cnt_q != 16'hffff) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // remote entry latch; set beats clear so a strobe is never lost
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      remote_q <= 1'b0;
    end else if (remote_quiet_i) begin
      remote_q <= 1'b1;
    end else if (srst_q || (state_q == ST_QUIET1 && state_d != ST_QUIET1)) begin
      remote_q <= 1'b0;
    end
  end

  // symbols since the later of the two entries
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q <= '0;
    end else if (srst_q || state_d != state_q || (remote_quiet_i && !remote_q)) begin
      wait_q <= '0;
    end else if (tick_q && wait_q != 16'hffff) begin
      wait_q <= wait_q + 1'b1;
    end
  end

  // overrun flag: the remote side kept the first quiet past its maximum
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ovr_q <= 1'b0;
    end else if (srst_q || state_q == ST_IDLE) begin
      ovr_q <= 1'b0;
    end else if (state_q == ST_QUIET1 && cnt_q >= QUIET1_MAX) begin
      ovr_q <= 1'b1;
    end
  end

  // encoder datapath: mapped point first, then gain and masking
  always_comb begin
    logic [1:0] ph;
    logic [8:0] gain;
    logic used;
    logic signed [DW-1:0] pre_re, pre_im;
    ph = (state_q != ST_IDLE) ? PH_DISC : ctrl_q[CTRL_PH_HI:CTRL_PH_LO];
    // upstream gains are unity; downstream clamped into 0..1
    gain = ctrl_q[CTRL_UP] ? GAIN_ONE :
           (tss_q[tone_idx_i] > GAIN_ONE ? GAIN_ONE : tss_q[tone_idx_i]);
    used = tone_idx_i != '0 && (int'(tone_idx_i) < NSC ||
           (ph == PH_TRAIN && ctrl_q[CTRL_ZFILL] && int'(tone_idx_i) < MINN));
    // training and analysis points are scaled to the reference level before gain
    pre_re = scale(map_re_i, level_q[LVL_REF_LO +: 9]);
    pre_im = scale(map_im_i, level_q[LVL_REF_LO +: 9]);
    z_re_d = '0;
    z_im_d = '0;
    case (ph)
      PH_HS: begin
        z_re_d = map_re_i;
        z_im_d = map_im_i;
      end
      PH_DISC: begin
        // only pilot states light tones; quiet states stay at zero
        if ((state_q == ST_PILOT1 || state_q == ST_PILOT2 || state_q == ST_INVP1) &&
            is_pilot(tone_idx_i)) begin
          // inverted pilot flips both bits, a half-turn on every tone
          z_re_d = scale(qam(prbs_i[0] ^ (state_q == ST_INVP1),
                             DW'(level_q[15:0])), gain);
          z_im_d = scale(qam(prbs_i[1] ^ (state_q == ST_INVP1),
                             DW'(level_q[15:0])), gain);
        end
      end
      PH_TRAIN: begin
        if (!mask_q[tone_idx_i]) begin
          z_re_d = scale(pre_re, gain);
          z_im_d = scale(pre_im, gain);
        end
      end
      default: begin
        if (offer_q[tone_idx_i] && !mask_q[tone_idx_i]) begin
          z_re_d = scale(pre_re, gain);
          z_im_d = scale(pre_im, gain);
        end
      end
    endcase
    if (!used && ph != PH_HS) begin
      z_re_d = '0;
      z_im_d = '0;
    end
  end

  // encoder output stage
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      z_valid_q <= 1'b0;
      z_idx_q <= '0;
      z_re_q <= '0;
      z_im_q <= '0;
    end else begin
      z_valid_q <= tone_valid_i;
      z_idx_q <= tone_idx_i;
      z_re_q <= tone_valid_i ? z_re_d : '0;
      z_im_q <= tone_valid_i ? z_im_d : '0;
    end
  end

  // read decode; unmapped addresses read zero
  always_comb begin
    rd_d = '0;
    if (addr_i == ADDR_CTRL) begin
      rd_d = {22'h0, ctrl_q};
    end else if (addr_i == ADDR_STAT) begin
      rd_d = {8'h0, ovr_q, remote_q, 3'h0, state_q, cnt_q};
    end else if (addr_i == ADDR_LEVEL) begin
      rd_d = level_q;
    end else if (addr_i[11] && int'(widx) < NT) begin
      rd_d = {23'h0, tss_q[widx]};
    end else begin
      for (int w = 0; w < NW; w++) begin
        if (in_region(addr_i, REGION_MASK) && int'(addr_i[7:2]) == w) begin
          rd_d = mask_stage_q[w*32 +: 32];
        end
        if (in_region(addr_i, REGION_OFFER) && int'(addr_i[7:2]) == w) begin
          rd_d = offer_q[w*32 +: 32];
        end
      end
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rd_i ? rd_d : '0;
    end
  end

  assign rdata_o = rdata_q;
  assign z_valid_o = z_valid_q;
  assign z_idx_o = z_idx_q;
  assign z_re_o = z_re_q;
  assign z_im_o = z_im_q;
  assign sym_tick_o = tick_q;
endmodule // itsds_top
`default_nettype wire

//--- verification/itsds_asserts.sv
// port checker for the tone shaper and discovery sequencer
`timescale 1ns/1ps
`default_nettype none
module itsds_checker
  import itsds_pkg::*;
#(
  parameter int NSC = 256,
  parameter int DW = 16
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [11:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic hs_end_i,
  input wire logic tone_valid_i,
  input wire logic [$clog2(2*NSC)-1:0] tone_idx_i,
  input wire logic signed [DW-1:0] map_re_i,
  input wire logic signed [DW-1:0] map_im_i,
  input wire logic z_valid_o,
  input wire logic [$clog2(2*NSC)-1:0] z_idx_o,
  input wire logic signed [DW-1:0] z_re_o,
  input wire logic signed [DW-1:0] z_im_o,
  input wire logic sym_tick_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic [1:0] ph_q;
  logic idle_q;
  logic zero;
  assign zero = (z_re_o == '0) && (z_im_o == '0);
  function automatic logic is_pilot(input int i);
    return i inside {11, 23, 35, 47, 59, 64, 71, 83, 95, 107, 119, 143, 179, 203, 227, 251};
  endfunction
  // shadow of phase and idle; only a soft reset brings the sequencer back
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_q <= PH_HS;
      idle_q <= 1'b1;
    end else if (wr_i && addr_i == ADDR_CTRL) begin
      ph_q <= wdata_i[CTRL_PH_HI:CTRL_PH_LO];
      idle_q <= idle_q | wdata_i[CTRL_SRST];
    end else if (hs_end_i) begin
      idle_q <= 1'b0;
    end
  end
  a_valid_follow: assert property (tone_valid_i |=> z_valid_o)
    else $error("output valid missing after a tone");
  a_valid_drop: assert property (!tone_valid_i |=> !z_valid_o && zero)
    else $error("output not quiet without a tone");
  a_idx_follow: assert property (tone_valid_i |=> z_idx_o == $past(tone_idx_i))
    else $error("output index differs from input");
  a_hs_passthru: assert property (tone_valid_i && idle_q && ph_q == PH_HS
    |=> z_re_o == $past(map_re_i) && z_im_o == $past(map_im_i))
    else $error("handshake tone was shaped");
  a_nonpilot_zero: assert property (tone_valid_i && (!idle_q || ph_q == PH_DISC)
    && !is_pilot(int'(tone_idx_i)) |=> zero)
    else $error("non pilot tone sent in discovery");
  a_upper_zero: assert property (tone_valid_i && idle_q && ph_q == PH_ANA
    && tone_idx_i >= NSC |=> zero)
    else $error("upper tone sent outside training");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data without a read");
  a_tick_pulse: assert property (sym_tick_o |=> !sym_tick_o [*2])
    else $error("symbol tick too close");
  c_hs_end: cover property (hs_end_i && idle_q);
  c_pilot_out: cover property (z_valid_o && !zero && !idle_q);
  c_read: cover property (rd_i ##1 rdata_o != '0);
endmodule // itsds_checker
bind itsds_top itsds_checker #(.NSC(NSC), .DW(DW)) i_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .hs_end_i(hs_end_i), .tone_valid_i(tone_valid_i), .tone_idx_i(tone_idx_i),
  .map_re_i(map_re_i), .map_im_i(map_im_i), .z_valid_o(z_valid_o), .z_idx_o(z_idx_o),
  .z_re_o(z_re_o), .z_im_o(z_im_o), .sym_tick_o(sym_tick_o));
`default_nettype wire

//--- verification/itsds_remote_model.sv
// remote transceiver model: announces its first quiet state after a delay
`timescale 1ns/1ps
`default_nettype none
module itsds_remote_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire logic [15:0] dly_i,
  input wire logic sym_tick_i,
  output logic quiet_o
);
  logic armed_q;
  logic [15:0] cnt_q;
  // counts symbols after its own session ends, then strobes once
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
      cnt_q <= 16'h0000;
      quiet_o <= 1'b0;
    end else begin
      quiet_o <= 1'b0;
      if (go_i) begin
        armed_q <= 1'b1;
        cnt_q <= 16'h0000;
      end else if (armed_q && cnt_q >= dly_i) begin
        armed_q <= 1'b0;
        quiet_o <= 1'b1;
      end else if (armed_q && sym_tick_i) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // itsds_remote_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench for the tone shaper and discovery sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import itsds_pkg::*;
  localparam logic [15:0] L = 16'h1000;
  localparam logic [31:0] M = 32'h0400_fc00;
  localparam logic [31:0] H = 32'h0200_fe00;
  localparam logic [8:0] PIL [16] = '{9'h00b, 9'h017, 9'h023, 9'h02f, 9'h03b, 9'h040,
    9'h047, 9'h053, 9'h05f, 9'h06b, 9'h077, 9'h08f, 9'h0b3, 9'h0cb, 9'h0e3, 9'h0fb};
  logic mclk_i, rst_i, wr_i, rd_i, hs_end_i, pcb_done_i, pcb_has_mask_i, tone_valid_i;
  logic go, rq, z_valid_o, sym_tick_o;
  logic [11:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rv, zv;
  logic [8:0] tone_idx_i, z_idx_o;
  logic signed [15:0] map_re_i, map_im_i, z_re_o, z_im_o;
  logic [1:0] prbs_i;
  logic [15:0] dly;
  int err_count, check_count, ticks, cyc, t0, t1;
  // short symbol period keeps the long pilot state affordable
  itsds_top #(.SYM_DIV(8)) i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hs_end_i(hs_end_i),
    .remote_quiet_i(rq), .pcb_done_i(pcb_done_i), .pcb_has_mask_i(pcb_has_mask_i),
    .tone_valid_i(tone_valid_i), .tone_idx_i(tone_idx_i), .map_re_i(map_re_i),
    .map_im_i(map_im_i), .prbs_i(prbs_i), .z_valid_o(z_valid_o), .z_idx_o(z_idx_o),
    .z_re_o(z_re_o), .z_im_o(z_im_o), .sym_tick_o(sym_tick_o));
  itsds_remote_model i_rem (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go), .dly_i(dly),
    .sym_tick_i(sym_tick_o), .quiet_o(rq));
  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // symbol count for durations, watchdog against a stuck sequencer
  always @(posedge mclk_i) begin
    if (sym_tick_o === 1'b1) ticks <= ticks + 1;
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rv & m, e);
  endtask
  // gap before each tone keeps control changes settled
  task automatic tone(input logic [8:0] i, input logic [1:0] p, input logic [31:0] m,
                      input logic [31:0] e);
    repeat (3) @(posedge mclk_i);
    tone_valid_i <= 1'b1;
    tone_idx_i <= i;
    prbs_i <= p;
    {map_re_i, map_im_i} <= m;
    @(posedge mclk_i);
    tone_valid_i <= 1'b0;
    #1 zv = {z_re_o, z_im_o};
    chk(zv, e);
    chk(32'(z_valid_o), 32'h1);
    chk(32'(z_idx_o), 32'(i));
  endtask
  task automatic pulse(input logic h, input logic g, input logic p, input logic k);
    @(posedge mclk_i);
    hs_end_i <= h;
    go <= g;
    pcb_done_i <= p;
    pcb_has_mask_i <= k;
    @(posedge mclk_i);
    {hs_end_i, go, pcb_done_i} <= 3'h0;
  endtask
  task automatic wait_st(input logic [2:0] s, output int t);
    do rd(ADDR_STAT); while (rv[18:16] !== s);
    t = ticks;
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    {wr_i, rd_i, hs_end_i, pcb_done_i, pcb_has_mask_i, tone_valid_i, go} = 7'h00;
    {addr_i, wdata_i, tone_idx_i, prbs_i, map_re_i, map_im_i} = '0;
    {err_count, check_count, ticks, cyc} = '0;
    dly = 16'h0064;
    rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rchk(ADDR_CTRL, 32'hffff_ffff, 32'h0);
    rchk(ADDR_LEVEL, 32'hffff_ffff, 32'h0100_1000);
    rchk(12'h814, 32'hffff_ffff, 32'h100);
    rchk(12'h00c, 32'hffff_ffff, 32'h0);
    tone(9'h005, 2'h0, M, M);
    tone(9'h12c, 2'h0, M, M);
    wr(12'h100, 32'h80);
    wr(12'h200, 32'hc0);
    pulse(1'b0, 1'b0, 1'b1, 1'b1);
    wr(ADDR_CTRL, 32'h200);
    tone(9'h007, 2'h0, M, 32'h0);
    tone(9'h006, 2'h0, M, M);
    tone(9'h12c, 2'h0, M, 32'h0);
    wr(ADDR_CTRL, 32'h240);
    tone(9'h12c, 2'h0, M, M);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    tone(9'h007, 2'h0, M, 32'h0);
    wr(ADDR_CTRL, 32'h300);
    tone(9'h006, 2'h0, M, M);
    tone(9'h007, 2'h0, M, 32'h0);
    tone(9'h008, 2'h0, M, 32'h0);
    tone(9'h12c, 2'h0, M, 32'h0);
    wr(12'h818, 32'h80);
    tone(9'h006, 2'h0, M, H);
    wr(12'h818, 32'h1ff);
    tone(9'h006, 2'h0, M, M);
    wr(12'h818, 32'h80);
    wr(ADDR_CTRL, 32'h308);
    tone(9'h006, 2'h0, M, M);
    wr(ADDR_CTRL, 32'h310);
    pulse(1'b0, 1'b0, 1'b1, 1'b0);
    tone(9'h007, 2'h0, M, M);
    // first run: remote late, fast recovery forces the short pilot, probing wanted
    wr(ADDR_CTRL, 32'h007);
    pulse(1'b1, 1'b1, 1'b0, 1'b0);
    // taken at the entry edge: a tick there is not yet counted, as in the state counter
    t0 = ticks;
    wait_st(3'h1, t1);
    tone(9'h00b, 2'h1, M, 32'h0);
    wait_st(3'h2, t1);
    chk(32'(t1 - t0 >= 612 && t1 - t0 <= 2148), 32'h1);
    foreach (PIL[k]) begin
      tone(PIL[k], 2'(k), M, {(k & 1) ? -L : L, (k & 2) ? -L : L});
      tone(PIL[k] + 9'h001, 2'(k), M, 32'h0);
    end
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    wait_st(3'h3, t0);
    chk(32'(t0 - t1), 32'h80);
    wait_st(3'h4, t1);
    chk(32'(t1 - t0), 32'h100);
    wait_st(3'h5, t0);
    chk(32'(t0 - t1), 32'h400);
    tone(9'h00b, 2'h1, M, {L, -L});
    wait_st(3'h7, t1);
    chk(32'(t1 - t0), 32'ha);
    // second run: remote first, long pilot, no probing
    wr(ADDR_CTRL, 32'h020);
    rchk(ADDR_STAT, 32'h00c7_0000, 32'h0);
    rchk(ADDR_CTRL, 32'hffff_ffff, 32'h0);
    wr(ADDR_CTRL, 32'h001);
    dly <= 16'h0000;
    pulse(1'b0, 1'b1, 1'b0, 1'b0);
    repeat (4) @(posedge mclk_i);
    rchk(ADDR_STAT, 32'h0040_0000, 32'h0040_0000);
    pulse(1'b1, 1'b0, 1'b0, 1'b0);
    t0 = ticks;
    wait_st(3'h1, t1);
    wait_st(3'h2, t1);
    chk(32'(t1 - t0 >= 512 && t1 - t0 <= 2048), 32'h1);
    rchk(ADDR_STAT, 32'h0040_0000, 32'h0);
    wait_st(3'h4, t0);
    wait_st(3'h6, t1);
    chk(32'(t1 - t0), 32'hf20);
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
